// ### logic/pfc_ctrl.sv
/*
 * Host-side controller for a 32K x 8 page-programmed flash on its async pins.
 * Accepts read, byte-load, program-page end, lock, unlock and chip erase orders
 * from a user port, times the pin strobes, and polls for cycle completion.
 * Assumes the flash pins are wired directly and the user holds cmd fields stable
 * while cmd_valid is high.
 */
`timescale 1ns/10ps
`default_nettype none
module pfc_ctrl
   import pfc_pkg::*;
#(
   parameter int unsigned WC_CYCLES    = WC_CYC,
   parameter int unsigned PWRON_CYCLES = PWRON_CYC,
   parameter logic [14:0] CMD_A1       = CMD_A1_DEF,
   parameter logic [14:0] CMD_A2       = CMD_A2_DEF,
   parameter logic [7:0]  CMD_D1       = CMD_D1_DEF,
   parameter logic [7:0]  CMD_D2       = CMD_D2_DEF,
   parameter logic [7:0]  CMD_LOCK     = CMD_LOCK_DEF,
   parameter logic [7:0]  CMD_UNLOCK   = 8'h80,
   parameter logic [7:0]  CMD_ERASE    = 8'h10
)
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              clk_en,
   input  wire logic              cmd_valid,
   input  wire logic [2:0]        cmd_op,
   input  wire logic [14:0]       cmd_addr,
   input  wire logic [7:0]        cmd_wdata,
   input  wire logic              cmd_locked,
   output logic                   cmd_ready,
   output logic                   rsp_valid,
   output logic [7:0]             rsp_rdata,
   output logic                   busy,
   output logic [14:0]            flash_addr,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic [7:0]             flash_dq_o,
   output logic                   flash_dq_oe,
   input  wire logic [7:0]        flash_dq_i
);
   // cmd_op: 0 read, 1 load byte, 2 finish page, 3 lock, 4 unlock, 5 erase.
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_LOAD = 3'h1;
   localparam logic [2:0] OP_END  = 3'h2;
   pfc_state_e   st_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] pwr_reg;
   logic [CNT_W-1:0] wc_reg;
   logic [2:0]   seq_reg;
   logic [2:0]   seq_len_reg;
   logic [2:0]   op_reg;
   logic [14:0]  addr_reg;
   logic [7:0]   data_reg;
   logic [7:0]   last_rd_reg;
   logic         first_poll_reg;
   logic         page_open_reg;
   logic [14:0]  seq_addr;
   logic [7:0]   seq_data;
   logic [7:0]   rd_sample;
   pfc_sync_if sif ();
   assign sif.raw = flash_dq_i;
   assign rd_sample = sif.clean;
   pfc_sync u_sync (
      .clk  (clk),
      .nrst (nrst),
      .ce   (clk_en),
      .s    (sif.snk)
   );
   // command prefix: step 0,1 unlock pair, 2 opcode, 3..5 erase tail.
   always_comb begin
      seq_addr = CMD_A1;
      seq_data = CMD_D1;
      case (seq_reg)
         3'd0: begin seq_addr = CMD_A1; seq_data = CMD_D1; end
         3'd1: begin seq_addr = CMD_A2; seq_data = CMD_D2; end
         3'd2: begin
            seq_addr = CMD_A1;
            seq_data = (op_reg == 3'h3 || op_reg == OP_LOAD) ? CMD_LOCK :
                       (op_reg == 3'h4) ? CMD_UNLOCK : 8'h80;
         end
         3'd3: begin seq_addr = CMD_A1; seq_data = CMD_D1; end
         3'd4: begin seq_addr = CMD_A2; seq_data = CMD_D2; end
         default: begin seq_addr = CMD_A1; seq_data = CMD_ERASE; end
      endcase
   end
   // ****************************************
   // Power-on hold-off and program cycle bound
   // ****************************************
   // power-on delay.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pwr_reg <= '0;
      end else if (clk_en && pwr_reg < CNT_W'(PWRON_CYCLES)) begin
         pwr_reg <= pwr_reg + 1'b1;
      end
   end
   // program cycle bound, so a dead part cannot hang the port.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wc_reg <= '0;
      end else if (clk_en) begin
         wc_reg <= (st_reg == PFC_IDLE) ? '0 : wc_reg + 1'b1;
      end
   end

   // ****************************************
   // Pin sequencer
   // ****************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg         <= PFC_IDLE;
         cnt_reg        <= '0;
         seq_reg        <= 3'd0;
         seq_len_reg    <= 3'd0;
         op_reg         <= OP_READ;
         addr_reg       <= '0;
         data_reg       <= 8'h00;
         last_rd_reg    <= 8'h00;
         first_poll_reg <= 1'b0;
         page_open_reg  <= 1'b0;
         cmd_ready      <= 1'b0;
         rsp_valid      <= 1'b0;
         rsp_rdata      <= 8'h00;
         busy           <= 1'b0;
         flash_addr     <= '0;
         flash_ce_n     <= 1'b1;
         flash_oe_n     <= 1'b1;
         flash_we_n     <= 1'b1;
         flash_dq_o     <= 8'h00;
         flash_dq_oe    <= 1'b0;
      end else if (clk_en) begin
         rsp_valid <= 1'b0;
         cmd_ready <= 1'b0;
         case (st_reg)
            PFC_IDLE: begin
               busy <= page_open_reg;
               if (page_open_reg) begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
               // silence past the byte-load window lets the flash program.
               if (page_open_reg && cnt_reg >= CNT_W'(BLC_DONE_CYC)) begin
                  page_open_reg  <= 1'b0;
                  first_poll_reg <= 1'b1;
                  cnt_reg        <= '0;
                  st_reg         <= PFC_POLL;
               end else if (cmd_valid && !cmd_ready && pwr_reg >= CNT_W'(PWRON_CYCLES)) begin
                  cmd_ready <= 1'b1;
                  op_reg    <= cmd_op;
                  addr_reg  <= (cmd_op == OP_END) ? addr_reg : cmd_addr;
                  data_reg  <= (cmd_op == OP_END) ? data_reg : cmd_wdata;
                  cnt_reg   <= '0;
                  busy      <= 1'b1;
                  flash_addr <= cmd_addr;
                  if (cmd_op == OP_READ) begin
                     // read with write strobe high, data released.
                     flash_dq_oe <= 1'b0;
                     flash_ce_n  <= 1'b0;
                     flash_oe_n  <= 1'b0;
                     st_reg      <= PFC_RDWT;
                  end else if (cmd_op == OP_END) begin
                     cnt_reg <= cnt_reg + 1'b1;
                  end else begin
                     // first byte of a locked page gets the prefix.
                     seq_reg     <= (cmd_op == OP_LOAD && !(cmd_locked && !page_open_reg))
                                    ? 3'd6 : 3'd0;
                     seq_len_reg <= (cmd_op == 3'h5) ? 3'd6 : 3'd3;
                     st_reg      <= PFC_SETUP;
                  end
               end
            end
            PFC_SETUP: begin
               // address and data set, output enable high first.
               flash_oe_n  <= 1'b1;
               flash_dq_oe <= 1'b1;
               flash_addr  <= (seq_reg == 3'd6) ? addr_reg : seq_addr;
               flash_dq_o  <= (seq_reg == 3'd6) ? data_reg : seq_data;
               flash_ce_n  <= 1'b0;
               cnt_reg     <= '0;
               st_reg      <= PFC_LOW;
            end
            PFC_LOW: begin
               // strobe low far longer than any glitch.
               flash_we_n <= 1'b0;
               cnt_reg    <= cnt_reg + 1'b1;
               if (cnt_reg >= CNT_W'(WP_CYC)) begin
                  // data still driven at the rising edge.
                  flash_we_n <= 1'b1;
                  cnt_reg    <= '0;
                  st_reg     <= PFC_HIGH;
               end
            end
            PFC_HIGH: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg >= CNT_W'(WPH_CYC)) begin
                  flash_ce_n  <= 1'b1;
                  flash_dq_oe <= 1'b0;
                  cnt_reg     <= '0;
                  if (seq_reg == 3'd6) begin
                     page_open_reg <= 1'b1;
                     st_reg        <= PFC_IDLE;
                  end else if (seq_reg + 3'd1 == seq_len_reg) begin
                     // command words done; a load then writes its byte, other orders let the flash run its cycle.
                     if (op_reg == OP_LOAD) begin
                        seq_reg <= 3'd6;
                        st_reg  <= PFC_SETUP;
                     end else begin
                        addr_reg      <= flash_addr;
                        data_reg      <= flash_dq_o;
                        page_open_reg <= 1'b1;
                        st_reg        <= PFC_IDLE;
                     end
                  end else begin
                     seq_reg <= seq_reg + 3'd1;
                     st_reg  <= PFC_SETUP;
                  end
               end
            end
            PFC_RDWT: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg >= CNT_W'(ACC_CYC + 3)) begin
                  flash_ce_n  <= 1'b1;
                  flash_oe_n  <= 1'b1;
                  last_rd_reg <= rd_sample;
                  cnt_reg     <= '0;
                  if (op_reg == OP_READ) begin
                     rsp_valid <= 1'b1;
                     rsp_rdata <= rd_sample;
                     st_reg    <= PFC_IDLE;
                  // two reads agree on bit 6 and, except after erase, bit 7 matches bit 7 of the last written byte.
                  end else if (wc_reg >= CNT_W'(WC_CYCLES) || (!first_poll_reg
                      && rd_sample[FLIP_BIT_POS] == last_rd_reg[FLIP_BIT_POS]
                      && (rd_sample[POLL_BIT_POS] == data_reg[POLL_BIT_POS]
                          || seq_len_reg == 3'd6))) begin
                     busy   <= 1'b0;
                     st_reg <= PFC_IDLE;
                  end else begin
                     first_poll_reg <= 1'b0;
                     st_reg         <= PFC_GAP;
                  end
               end
            end
            PFC_GAP: begin
               // Output enable stays high long enough for the part to flip bit 6.
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg >= CNT_W'(WPH_CYC)) begin
                  st_reg <= PFC_POLL;
               end
            end
            PFC_POLL: begin
               // polling also covers a timer started by a refused write.
               op_reg      <= OP_END;
               flash_addr  <= addr_reg;
               flash_dq_oe <= 1'b0;
               flash_ce_n  <= 1'b0;
               flash_oe_n  <= 1'b0;
               cnt_reg     <= '0;
               st_reg      <= PFC_RDWT;
            end
            default: st_reg <= PFC_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### logic/pfc_pkg.sv
/*
 * Package for the page-program flash controller: pin widths, timing figures and
 * derived cycle counts, command defaults and the controller state encoding.
 * Assumes a 20 MHz system clock.
 */
package pfc_pkg;
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned ADDR_W          = 15;
   localparam int unsigned DATA_W          = 8;
   localparam int unsigned PAGE_BYTES      = 64;
   localparam int unsigned OFS_W           = 6;
   localparam int unsigned PAGE_LSB        = 6;
   localparam int unsigned POLL_BIT_POS    = 7;
   localparam int unsigned FLIP_BIT_POS    = 6;
   // Strobe phases: 90 ns low, 100 ns high.
   localparam int unsigned T_WP_NS         = 90;
   localparam int unsigned T_WPH_NS        = 100;
   localparam int unsigned T_ACC_NS        = 150;
   localparam int unsigned T_BLC_US        = 150;
   localparam int unsigned T_WC_MS         = 10;
   localparam int unsigned T_PWRON_MS      = 5;
   localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
   localparam int unsigned WP_CYC          = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned WPH_CYC         = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned ACC_CYC         = (T_ACC_NS + CLK_NS - 1) / CLK_NS + 1;
   // Longest gap between loads rounds down, with margin for the command turnaround.
   localparam int unsigned BLC_CYC         = T_BLC_US * (CLK_HZ / 1_000_000) - 16;
   // Polling waits past the longest window, so the part has surely started its cycle.
   localparam int unsigned BLC_DONE_CYC    = T_BLC_US * (CLK_HZ / 1_000_000) + 16;
   localparam int unsigned WC_CYC          = T_WC_MS * (CLK_HZ / 1000);
   localparam int unsigned PWRON_CYC       = T_PWRON_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W           = 24;
   localparam logic [14:0] CMD_A1_DEF      = 15'h5555;
   localparam logic [14:0] CMD_A2_DEF      = 15'h2aaa;
   localparam logic [7:0]  CMD_D1_DEF      = 8'haa;
   localparam logic [7:0]  CMD_D2_DEF      = 8'h55;
   localparam logic [7:0]  CMD_LOCK_DEF    = 8'ha0;

   typedef enum logic [6:0] {
      PFC_IDLE  = 7'h01,
      PFC_SETUP = 7'h02,
      PFC_LOW   = 7'h04,
      PFC_HIGH  = 7'h08,
      PFC_RDWT  = 7'h10,
      PFC_GAP   = 7'h20,
      PFC_POLL  = 7'h40
   } pfc_state_e;
endpackage

// ### logic/pfc_sync_if.sv
/*
 * Carrier between the controller and its pin synchroniser.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface pfc_sync_if;
   logic [7:0] raw;
   logic [7:0] clean;
   modport src (output raw, input clean);
   modport snk (input raw, output clean);
endinterface
`default_nettype wire

// ### logic/pfc_sync.sv
/*
 * Three-stage synchroniser for the data pins read back from the flash.
 * A bit changes only when the second and third stages agree.
 */
`timescale 1ns/10ps
`default_nettype none
module pfc_sync
   import pfc_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ce,
   pfc_sync_if.snk   s
);
   logic [7:0] s1_reg;
   logic [7:0] s2_reg;
   logic [7:0] s3_reg;
   logic [7:0] clean_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= 8'h00;
         s2_reg <= 8'h00;
         s3_reg <= 8'h00;
      end else if (ce) begin
         s1_reg <= s.raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               clean_reg[i] <= 1'b0;
            end else if (ce && (s2_reg[i] == s3_reg[i])) begin
               clean_reg[i] <= s3_reg[i];
            end
         end
      end
   endgenerate

   assign s.clean = clean_reg;
endmodule
`default_nettype wire

// ### tb/pfc_ctrl_sva.sv
/* Pin timing checker for pfc_ctrl.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
module pfc_ctrl_chk #(
   parameter int unsigned PWRON_CYCLES = 100
)(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire logic        busy,
   input wire logic [14:0] flash_addr,
   input wire logic        flash_ce_n,
   input wire logic        flash_oe_n,
   input wire logic        flash_we_n,
   input wire logic [7:0]  flash_dq_o,
   input wire logic        flash_dq_oe
);
   // ************************************************************
   // Assertions
   // ************************************************************
   int unsigned up_cnt;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) up_cnt <= 0;
      else if (up_cnt < PWRON_CYCLES) up_cnt <= up_cnt + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_WE_NEEDS_CE: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
      else $error("write strobe without select");
   AST_NO_WRITE_READ: assert property (!flash_oe_n |-> flash_we_n && !flash_dq_oe)
      else $error("write or drive during read");
   AST_ADDR_STABLE: assert property (!flash_we_n |-> $stable(flash_addr))
      else $error("address moved under strobe");
   AST_DATA_STABLE: assert property (!flash_we_n |-> flash_dq_oe && $stable(flash_dq_o))
      else $error("data moved under strobe");
   AST_LOW_WIDTH: assert property ($fell(flash_we_n) |-> !flash_we_n [*2])
      else $error("strobe low too short");
   AST_HIGH_WIDTH: assert property ($rose(flash_we_n) |-> flash_we_n [*2])
      else $error("strobe high too short");
   AST_PON_WRITE: assert property ($fell(flash_we_n) |-> up_cnt >= PWRON_CYCLES)
      else $error("strobe inside power delay");
   AST_READY_CAUSE: assert property (cmd_ready |-> $past(cmd_valid) && busy)
      else $error("ready without order");
   AST_DRIVE_SELECTED: assert property (flash_dq_oe |-> !flash_ce_n)
      else $error("data driven while deselected");
   COV_LOAD: cover property ($fell(flash_we_n));
   COV_READ: cover property ($fell(flash_oe_n));
   COV_DONE: cover property ($fell(busy));
endmodule
bind pfc_ctrl pfc_ctrl_chk #(.PWRON_CYCLES(PWRON_CYCLES)) u_chk (.clk, .nrst, .cmd_valid,
   .cmd_ready, .busy, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_o,
   .flash_dq_oe);
`default_nettype wire

// ### tb/pfc_flash_model.sv
/* Behavioural page flash for the controller bench.
   Assumes pins sampled on the bench clock, so glitches shorter than it are unseen. */
`timescale 1ns/10ps
`default_nettype none
module pfc_flash_model #(
   parameter int PROG = 60,
   parameter int GAP  = 3000,
   parameter int PON  = 50
)(
   input  wire logic        clk,
   input  wire logic [14:0] addr,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [7:0]  dq_w,
   output logic [7:0]       dq_r
);
   // ************************************************************
   // Array, page latch and program timer
   // ************************************************************
   logic [7:0]  mem [0:32767];
   logic [7:0]  pg [0:63];
   logic [63:0] ld = '0;
   logic [14:0] la, a1, a2;
   logic [7:0]  last, h1, h2;
   logic [7:0]  q = 8'h00;
   logic [8:0]  pgn;
   logic        wr_q = 1'b0, rd_q = 1'b0, tog = 1'b0, pfx = 1'b0, ers = 1'b0;
   logic        lock = 1'b0, lock_nx = 1'b0;
   int          gap_c = 0, prog_c = 0, pon_c = 0;
   wire logic   wr = !ce_n && !we_n && oe_n;
   wire logic   rd = !ce_n && !oe_n;
   initial for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ 8'h5a;
   // released bus shows no stale value
   assign dq_r = rd ? (prog_c > 0 ? {~last[7], tog, last[5:0]} : mem[addr]) : ~q;
   always @(posedge clk) begin
      if (rd) q <= dq_r;
      wr_q <= wr;
      rd_q <= rd;
      pon_c <= pon_c + 1;
      if (rd && !rd_q && prog_c > 0) tog <= !tog;
      if (wr && !wr_q) la <= addr;
      if (wr_q && !wr && prog_c == 0 && pon_c >= PON) begin
         pg[la[5:0]] <= dq_w;
         ld[la[5:0]] <= 1'b1;
         pgn <= la[14:6];
         last <= dq_w;
         gap_c <= GAP;
         {h2, h1, a2, a1} <= {h1, dq_w, a1, la};
         if (a2 == 15'h5555 && h2 == 8'haa && a1 == 15'h2aaa && h1 == 8'h55 && la == 15'h5555) begin
            pfx <= 1'b1;
            if (dq_w == 8'ha0) lock_nx <= 1'b1;
            if (dq_w == 8'h80) lock_nx <= 1'b0;
            if (dq_w == 8'h10) ers <= 1'b1;
         end
      end
      if (gap_c > 0 && !wr) gap_c <= gap_c - 1;
      if (gap_c == 1 && !wr) prog_c <= PROG;
      if (prog_c > 0) prog_c <= prog_c - 1;
      if (prog_c == 1) begin
         if (ers) for (int i = 0; i < 32768; i++) mem[i] <= 8'hff;
         if (pfx || !lock) for (int i = 0; i < 64; i++) if (ld[i]) mem[{pgn, i[5:0]}] <= pg[i];
         lock <= lock_nx;
         ld <= '0;
         pfx <= 1'b0;
         ers <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
/* Self-checking bench for pfc_ctrl against the flash model.
   Assumes a 20 MHz clock and shortened power-on count. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
   // ************************************************************
   // Stimulus and checks
   // ************************************************************
   logic clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, cmd_locked = 1'b0, clk_en = 1'b1;
   logic [2:0] cmd_op = '0;
   logic [14:0] cmd_addr = '0, flash_addr;
   logic [7:0] cmd_wdata = '0, rsp_rdata, flash_dq_o, flash_dq_i, r;
   logic cmd_ready, rsp_valid, busy, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
   int errors = 0, compares = 0, cyc = 0, n;
   always #25 clk = ~clk;
   pfc_ctrl #(.WC_CYCLES(400), .PWRON_CYCLES(100)) dut (.clk, .nrst, .clk_en, .cmd_valid,
      .cmd_op, .cmd_addr, .cmd_wdata, .cmd_locked, .cmd_ready, .rsp_valid, .rsp_rdata, .busy,
      .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_o, .flash_dq_oe, .flash_dq_i);
   pfc_flash_model u_flash (.clk, .addr(flash_addr), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
      .we_n(flash_we_n), .dq_w(flash_dq_o), .dq_r(flash_dq_i));
   task automatic report_and_stop;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmd(input logic [2:0] op, input logic [14:0] a, input logic [7:0] d);
      @(posedge clk);
      n = 0;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_valid <= 1'b1;
      do begin @(posedge clk); n++; end while (cmd_ready !== 1'b1 && n < 4000);
      cmd_valid <= 1'b0;
      if (op == 3'd0) begin
         do @(posedge clk); while (rsp_valid !== 1'b1 && n++ < 4000);
         r = rsp_rdata;
      end
      if (n >= 4000) errors++;
   endtask
   task automatic wait_idle(input int min);
      n = 0;
      do begin @(posedge clk); n++; end while (busy !== 1'b0 && n < 8000);
      `CHK(n >= min && n < 8000, 1'b1)
   endtask
   task automatic t_page;
      logic [5:0] ofs [4] = '{6'd3, 6'd0, 6'd2, 6'd1};
      foreach (ofs[i]) cmd(3'd1, {9'h005, ofs[i]}, {2'b11, ofs[i]});
      cmd(3'd2, 15'h0140, 8'h00);
      wait_idle(60);
      foreach (ofs[i]) begin
         cmd(3'd0, {9'h005, ofs[i]}, 8'h00);
         `CHK(r, {2'b11, ofs[i]})
      end
      $display("test page done");
   endtask
   task automatic t_lock;
      cmd(3'd3, 15'h0000, 8'h00);
      wait_idle(60);
      cmd_locked <= 1'b1;
      cmd(3'd1, 15'h0800, 8'hf7);
      cmd(3'd2, 15'h0800, 8'h00);
      wait_idle(60);
      cmd(3'd0, 15'h0800, 8'h00);
      `CHK(r, 8'hf7)
      cmd_locked <= 1'b0;
      cmd(3'd1, 15'h0800, 8'h88);
      cmd(3'd2, 15'h0800, 8'h00);
      wait_idle(0);
      // The device may still be timing a write that changes nothing; outwait gap and cycle.
      repeat (3200) @(posedge clk);
      cmd(3'd0, 15'h0800, 8'h00);
      `CHK(r, 8'hf7)
      cmd_locked <= 1'b1;
      cmd(3'd4, 15'h0000, 8'h00);
      wait_idle(60);
      cmd_locked <= 1'b0;
      cmd(3'd1, 15'h0800, 8'h22);
      cmd(3'd2, 15'h0800, 8'h00);
      wait_idle(60);
      cmd(3'd0, 15'h0800, 8'h00);
      `CHK(r, 8'h22)
      $display("test lock done");
   endtask
   task automatic t_freeze;
      @(posedge clk);
      clk_en <= 1'b0;
      cmd_op <= 3'd0;
      cmd_addr <= 15'h0123;
      cmd_valid <= 1'b1;
      repeat (10) @(posedge clk);
      `CHK({cmd_ready, flash_oe_n}, 2'b01)
      clk_en <= 1'b1;
      cmd_valid <= 1'b0;
      cmd(3'd0, 15'h0123, 8'h00);
      `CHK(r, 8'h23 ^ 8'h5a)
      $display("test freeze done");
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         report_and_stop;
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      `CHK({flash_we_n, flash_ce_n, flash_dq_oe}, 3'b110)
      nrst <= 1'b1;
      cmd(3'd0, 15'h0123, 8'h00);
      `CHK(n >= 100, 1'b1)
      `CHK(r, 8'h23 ^ 8'h5a)
      $display("test power done");
      t_freeze;
      t_page;
      cmd(3'd1, 15'h0400, 8'hbc);
      wait_idle(3000);
      cmd(3'd0, 15'h0400, 8'h00);
      `CHK(r, 8'hbc)
      $display("test silence done");
      t_lock;
      cmd(3'd5, 15'h0000, 8'h00);
      wait_idle(60);
      cmd(3'd0, 15'h0123, 8'h00);
      `CHK(r, 8'hff)
      $display("test erase done");
      report_and_stop;
   end
endmodule
`default_nettype wire
